//--- vca_buffer.sv
// Small FIFO decoupling the gain datapath from the video receiver.
// Assumes one clock; a word is moved when valid and ready are both high.
`timescale 1ns/1ps
module vca_buffer #(
  parameter int WIDTH = vca_pkg::PIX_W,
  parameter int DEPTH = vca_pkg::BUF_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  vca_stream_if.snk wr,
  vca_stream_if.src rd,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [$clog2(DEPTH+1)-1:0] count_reg;
  wire do_wr;
  wire do_rd;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  // Full stalls the writer so a receiver stall loses no word
  assign wr.ready = (count_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign rd.valid = (count_reg != '0);
  assign rd.data = mem[rd_ptr_reg];
  assign do_wr = wr.valid && wr.ready;
  assign do_rd = rd.valid && rd.ready;
  assign level = count_reg;

  // Pointer wrap shared by both pointers
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // Storage, no reset needed on data
  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= wr.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) wr_ptr_reg <= next_ptr(wr_ptr_reg);
      if (do_rd) rd_ptr_reg <= next_ptr(rd_ptr_reg);
      if (do_wr && !do_rd) count_reg <= count_reg + 1'b1;
      else if (do_rd && !do_wr) count_reg <= count_reg - 1'b1;
    end
  end
endmodule

//--- vca_color_adjust.sv
// Colour adjust stage: luma contrast gain, U/V saturation gains and
// hue offset on the chroma demodulation phase, with an APB register file.
// Assumes the pixel stream arrives on pclk from same-clock logic.
//
// Behaviour
// - Luma times 9-bit contrast, 0x0D8 unity
// - U gain is high bit joined low byte
// - U low byte resets 0xFE, unity 254
// - V gain is high bit joined low byte
// - V low byte resets 0xB4, unity 180
// - Signed hue code added to demodulation phase
// - Hue offset only for NTSC-type decoding
// - Hue register resets zero, fully read/write
// - Control bits 2,1,0 are gain high bits
// - Contrast low byte resets 0xD8, joins high
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module vca_color_adjust (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pixel input
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  input wire logic [7:0] pix_in_luma,
  input wire logic [7:0] pix_in_u,
  input wire logic [7:0] pix_in_v,
  input wire logic [9:0] pix_in_phase,
  // Pixel output
  output logic pix_out_valid,
  input wire logic pix_out_ready,
  output logic [7:0] pix_out_luma,
  output logic [7:0] pix_out_u,
  output logic [7:0] pix_out_v,
  output logic [9:0] pix_out_phase
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] misc_ctrl_reg;
  logic [7:0] luma_gain_low_byte_reg;
  logic [7:0] u_gain_low_byte_reg;
  logic [7:0] v_gain_low_byte_reg;
  logic [7:0] hue_phase_offset_reg;
  vca_pkg::vca_std_t video_std_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup_phase;
  wire access_phase;
  wire wr_access;
  wire wr_lane0;
  wire hit_misc;
  wire hit_luma;
  wire hit_u;
  wire hit_v;
  wire hit_hue;
  wire hit_std;
  wire hit_status;
  wire addr_mapped;

  // Full word compare: unmapped and misaligned both miss
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  // Shared by the read mux and the write strobes
  assign hit_misc = addr_hit(paddr, vca_pkg::OFS_MISC_CTRL);
  assign hit_luma = addr_hit(paddr, vca_pkg::OFS_LUMA_GAIN_LOW);
  assign hit_u = addr_hit(paddr, vca_pkg::OFS_U_GAIN_LOW);
  assign hit_v = addr_hit(paddr, vca_pkg::OFS_V_GAIN_LOW);
  assign hit_hue = addr_hit(paddr, vca_pkg::OFS_HUE_PHASE_OFFSET);
  assign hit_std = addr_hit(paddr, vca_pkg::OFS_VIDEO_STD);
  assign hit_status = addr_hit(paddr, vca_pkg::OFS_STATUS);
  assign addr_mapped = hit_misc | hit_luma | hit_u | hit_v | hit_hue | hit_std | hit_status;

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  // Writes land only in the access phase; byte lane 0 carries every field
  assign wr_access = access_phase && pwrite && addr_mapped;
  assign wr_lane0 = wr_access && pstrb[0];

  // Zero wait states; unmapped address answers with an error
  assign pready = 1'b1;
  assign pslverr = access_phase && !addr_mapped;
  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // Gain codes
  // ----------------------------------------------------------------
  wire [8:0] luma_gain_value;
  wire [8:0] u_gain_value;
  wire [8:0] v_gain_value;
  wire luma_gain_high_bit;
  wire u_gain_high_bit;
  wire v_gain_high_bit;

  // High bits live in the shared control register
  assign luma_gain_high_bit = misc_ctrl_reg[vca_pkg::MISC_LUMA_HIGH_POS];
  assign u_gain_high_bit = misc_ctrl_reg[vca_pkg::MISC_U_HIGH_POS];
  assign v_gain_high_bit = misc_ctrl_reg[vca_pkg::MISC_V_HIGH_POS];
  assign luma_gain_value = {luma_gain_high_bit, luma_gain_low_byte_reg};
  assign u_gain_value = {u_gain_high_bit, u_gain_low_byte_reg};
  assign v_gain_value = {v_gain_high_bit, v_gain_low_byte_reg};

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  wire [1:0] buf_level;
  wire [31:0] status_word;
  wire hue_active;

  // Hue is bypassed unless the decoder runs an NTSC-type standard
  assign hue_active = (video_std_reg == vca_pkg::VCA_STD_NTSC);
  assign status_word = {24'h0000_00, 3'b000, hue_active, 1'b0,
                        pix_out_valid, buf_level};

  // ----------------------------------------------------------------
  // Read mux, sampled in the setup phase
  // ----------------------------------------------------------------
  // Data is ready in the access phase without a wait state
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (hit_misc) prdata_next = {24'h0000_00, misc_ctrl_reg};
    if (hit_luma) prdata_next = {24'h0000_00, luma_gain_low_byte_reg};
    if (hit_u) prdata_next = {24'h0000_00, u_gain_low_byte_reg};
    if (hit_v) prdata_next = {24'h0000_00, v_gain_low_byte_reg};
    if (hit_hue) prdata_next = {24'h0000_00, hue_phase_offset_reg};
    if (hit_std) prdata_next = {30'h0000_0000, video_std_reg};
    if (hit_status) prdata_next = status_word;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Whole byte stored: neighbours of the gain high bits stay intact
  // only if software writes back what it read
  wire wr_misc;
  wire wr_luma;
  wire wr_u;
  wire wr_v;
  wire wr_hue;
  wire wr_std;

  // One strobe per register; status takes no write
  assign wr_misc = wr_lane0 && hit_misc;
  assign wr_luma = wr_lane0 && hit_luma;
  assign wr_u = wr_lane0 && hit_u;
  assign wr_v = wr_lane0 && hit_v;
  assign wr_hue = wr_lane0 && hit_hue;
  assign wr_std = wr_lane0 && hit_std;

  // Shared control byte; only bits 2:0 feed the datapath
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_ctrl_reg <= vca_pkg::RST_MISC_CTRL;
    end else if (wr_misc) begin
      misc_ctrl_reg <= pwdata[7:0];
    end
  end

  // Contrast low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      luma_gain_low_byte_reg <= vca_pkg::RST_LUMA_GAIN_LOW;
    end else if (wr_luma) begin
      luma_gain_low_byte_reg <= pwdata[7:0];
    end
  end

  // U gain low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      u_gain_low_byte_reg <= vca_pkg::RST_U_GAIN_LOW;
    end else if (wr_u) begin
      u_gain_low_byte_reg <= pwdata[7:0];
    end
  end

  // V gain low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v_gain_low_byte_reg <= vca_pkg::RST_V_GAIN_LOW;
    end else if (wr_v) begin
      v_gain_low_byte_reg <= pwdata[7:0];
    end
  end

  // Hue code; every value is a legal phase step, no clamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hue_phase_offset_reg <= vca_pkg::RST_HUE_PHASE_OFFSET;
    end else if (wr_hue) begin
      hue_phase_offset_reg <= pwdata[7:0];
    end
  end

  // Decoding standard; decides whether the hue offset applies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      video_std_reg <= vca_pkg::VCA_STD_NTSC;
    end else if (wr_std) begin
      video_std_reg <= vca_pkg::vca_std_t'(pwdata[1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Gain arithmetic
  // ----------------------------------------------------------------
  // Scale by code/unity with rounding, then clamp to the sample range.
  // The reciprocal trades a divider for one extra multiplier.
  function automatic logic [7:0] apply_gain(
    input logic signed [9:0] sample,
    input logic [8:0] code,
    input logic [9:0] recip,
    input logic signed [9:0] lo,
    input logic signed [9:0] hi
  );
    logic signed [31:0] prod;
    logic signed [31:0] scaled;
    logic [7:0] res;
    prod = 32'sh0000_0000;
    scaled = 32'sh0000_0000;
    res = 8'h00;
    prod = sample * $signed({1'b0, code}) * $signed({1'b0, recip});
    scaled = (prod + vca_pkg::GAIN_ROUND) >>> vca_pkg::GAIN_FRAC_BITS;
    if (scaled > 32'(hi)) begin
      res = hi[7:0];
    end else if (scaled < 32'(lo)) begin
      res = lo[7:0];
    end else begin
      res = scaled[7:0];
    end
    apply_gain = res;
  endfunction

  wire [7:0] luma_scaled;
  wire [7:0] u_scaled;
  wire [7:0] v_scaled;
  wire [9:0] hue_offset_ext;
  wire [9:0] phase_adjusted;

  // Live register values: a write shows on the next pixel accepted
  assign luma_scaled = apply_gain($signed({2'b00, pix_in_luma}), luma_gain_value,
                                  vca_pkg::LUMA_RECIP, vca_pkg::LUMA_MIN,
                                  vca_pkg::LUMA_MAX);
  assign u_scaled = apply_gain($signed({{2{pix_in_u[7]}}, pix_in_u}), u_gain_value,
                               vca_pkg::U_RECIP, vca_pkg::CHROMA_MIN,
                               vca_pkg::CHROMA_MAX);
  assign v_scaled = apply_gain($signed({{2{pix_in_v[7]}}, pix_in_v}), v_gain_value,
                               vca_pkg::V_RECIP, vca_pkg::CHROMA_MIN,
                               vca_pkg::CHROMA_MAX);

  // ----------------------------------------------------------------
  // Hue offset
  // ----------------------------------------------------------------
  // One code step is one phase step of 360/1024 degrees; phase wraps
  assign hue_offset_ext = hue_active ?
                          {{2{hue_phase_offset_reg[7]}}, hue_phase_offset_reg} :
                          10'h000;
  assign phase_adjusted = 10'(pix_in_phase + hue_offset_ext);

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  vca_stream_if #(.WIDTH(vca_pkg::PIX_W)) proc_s ();
  vca_stream_if #(.WIDTH(vca_pkg::PIX_W)) out_s ();

  assign proc_s.valid = pix_in_valid;
  assign proc_s.data = {luma_scaled, u_scaled, v_scaled, phase_adjusted};
  // Back-pressure from the receiver reaches the source here
  assign pix_in_ready = proc_s.ready;
  assign out_s.ready = pix_out_ready;

  vca_buffer #(
    .WIDTH(vca_pkg::PIX_W),
    .DEPTH(vca_pkg::BUF_DEPTH)
  ) u_out_buffer (
    .pclk(pclk),
    .presetn(presetn),
    .wr(proc_s),
    .rd(out_s),
    .level(buf_level)
  );

  // Data outputs come from the buffer storage flops
  assign pix_out_valid = out_s.valid;
  assign pix_out_luma = out_s.data[33:26];
  assign pix_out_u = out_s.data[25:18];
  assign pix_out_v = out_s.data[17:10];
  assign pix_out_phase = out_s.data[9:0];

endmodule

//--- vca_color_adjust_props.sv
// Assertion checker for the colour adjust stage, bound to its top ports.
// Assumes one clock pclk and asynchronous active-low presetn.
`timescale 1ns/1ps
module vca_color_adjust_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pix_in_valid,
  input wire logic pix_in_ready,
  input wire logic [7:0] pix_in_luma,
  input wire logic [7:0] pix_in_u,
  input wire logic [7:0] pix_in_v,
  input wire logic [9:0] pix_in_phase,
  input wire logic pix_out_valid,
  input wire logic pix_out_ready,
  input wire logic [7:0] pix_out_luma,
  input wire logic [7:0] pix_out_u,
  input wire logic [7:0] pix_out_v,
  input wire logic [9:0] pix_out_phase
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic clean_reg;
  logic clean_next;
  logic take_w;
  logic mapped_w;
  // Defaults trusted only until software writes anything at all
  assign clean_next = clean_reg & ~(psel & penable & pwrite);
  assign take_w = pix_in_valid & pix_in_ready & ~pix_out_valid & clean_reg;
  assign mapped_w = paddr inside {12'h02C, 12'h030, 12'h034, 12'h038, 12'h03C, 12'h048, 12'h04C};
  // Clean flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clean_reg <= 1'b1;
    end else begin
      clean_reg <= clean_next;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_luma_unity;
    take_w |=> pix_out_valid && pix_out_luma == $past(pix_in_luma);
  endproperty
  a_luma_unity: assert property (p_luma_unity) else $error("luma altered at reset gain");
  property p_u_unity;
    take_w |=> pix_out_valid && pix_out_u == $past(pix_in_u);
  endproperty
  a_u_unity: assert property (p_u_unity) else $error("u altered at reset gain");
  property p_v_unity;
    take_w |=> pix_out_valid && pix_out_v == $past(pix_in_v);
  endproperty
  a_v_unity: assert property (p_v_unity) else $error("v altered at reset gain");
  property p_phase_zero;
    take_w |=> pix_out_phase == $past(pix_in_phase);
  endproperty
  a_phase_zero: assert property (p_phase_zero) else $error("phase moved at reset hue");
  property p_rd_ctrl;
    psel && penable && !pwrite && paddr == 12'h02C && clean_reg |-> prdata == 32'h0000_0020;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control reset value wrong");
  property p_rd_luma;
    psel && penable && !pwrite && paddr == 12'h030 && clean_reg |-> prdata == 32'h0000_00D8;
  endproperty
  a_rd_luma: assert property (p_rd_luma) else $error("luma gain reset value wrong");
  property p_err;
    psel && penable |-> pready && pslverr == !mapped_w;
  endproperty
  a_err: assert property (p_err) else $error("bus answer wrong for address");
  property p_hold;
    pix_out_valid && !pix_out_ready |=> pix_out_valid &&
      $stable({pix_out_luma, pix_out_u, pix_out_v, pix_out_phase});
  endproperty
  a_hold: assert property (p_hold) else $error("stalled output word changed");
  property p_full;
    pix_out_valid && !pix_out_ready && pix_in_valid && pix_in_ready |=> !pix_in_ready;
  endproperty
  a_full: assert property (p_full) else $error("input ready with buffer full");
endmodule

bind vca_color_adjust vca_color_adjust_props u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .pix_in_valid, .pix_in_ready, .pix_in_luma,
  .pix_in_u, .pix_in_v, .pix_in_phase, .pix_out_valid, .pix_out_ready, .pix_out_luma,
  .pix_out_u, .pix_out_v, .pix_out_phase);

//--- vca_color_adjust_tb_top.sv
// Self-checking bench for the colour adjust stage.
// Assumes a zero-wait APB slave and a two-word output buffer.
`timescale 1ns/1ps
module vca_color_adjust_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb;
  logic pix_in_valid, pix_in_ready, pix_out_valid, pix_out_ready;
  logic [7:0] pix_in_luma, pix_in_u, pix_in_v, pix_out_luma, pix_out_u, pix_out_v;
  logic [9:0] pix_in_phase, pix_out_phase;
  logic [7:0] ctrl_s = 8'h20, lg_s = 8'hD8, ug_s = 8'hFE, vg_s = 8'hB4, hue_s = 8'h00;
  logic [1:0] std_s = 2'h0;
  logic [33:0] exp_q[$];
  logic [8:0] codes [5] = '{9'h000, 9'h001, 9'h080, 9'h1FF, 9'h0D8};
  int err_total = 0;
  int comparisons = 0;

  vca_color_adjust uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .pix_in_valid, .pix_in_ready, .pix_in_luma, .pix_in_u,
    .pix_in_v, .pix_in_phase, .pix_out_valid, .pix_out_ready, .pix_out_luma, .pix_out_u,
    .pix_out_v, .pix_out_phase);

  // ------------------------------------------------------------
  // Tasks and reference arithmetic
  // ------------------------------------------------------------
  task automatic check(string what, logic [33:0] seen, logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer; an idle edge first so strobes never toggle twice at once
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, wr, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d, 4'hF, rdv, erv);
    case (a)
      12'h02C: ctrl_s = d[7:0];
      12'h030: lg_s = d[7:0];
      12'h034: ug_s = d[7:0];
      12'h038: vg_s = d[7:0];
      12'h03C: hue_s = d[7:0];
      12'h048: std_s = d[1:0];
      default: ;
    endcase
  endtask
  task automatic rd_chk(logic [11:0] a, logic [31:0] exp, logic eerr);
    apb(1'b0, a, 32'h0, 4'hF, rdv, erv);
    check("prdata", {2'h0, rdv}, {2'h0, exp});
    check("pslverr", {33'h0, erv}, {33'h0, eerr});
  endtask
  // Rounded, clamped gain product; signed for chroma
  function automatic logic [7:0] gain(logic [7:0] s, logic sg, logic [8:0] c, int r);
    int p;
    p = ((sg ? int'($signed(s)) : int'(s)) * int'(c) * r + 32768) >>> 16;
    if (sg) p = (p > 127) ? 127 : ((p < -128) ? -128 : p);
    else p = (p > 255) ? 255 : p;
    return p[7:0];
  endfunction
  task automatic send(logic [7:0] l, logic [7:0] u, logic [7:0] v, logic [9:0] ph);
    @(posedge pclk);
    {pix_in_valid, pix_in_luma, pix_in_u, pix_in_v, pix_in_phase} <= {1'b1, l, u, v, ph};
    exp_q.push_back({gain(l, 1'b0, {ctrl_s[2], lg_s}, int'(vca_pkg::LUMA_RECIP)),
      gain(u, 1'b1, {ctrl_s[1], ug_s}, int'(vca_pkg::U_RECIP)),
      gain(v, 1'b1, {ctrl_s[0], vg_s}, int'(vca_pkg::V_RECIP)),
      (std_s == 2'h0) ? 10'(ph + {{2{hue_s[7]}}, hue_s}) : ph});
    do begin
      @(posedge pclk);
    end while (pix_in_ready !== 1'b1);
    pix_in_valid <= 1'b0;
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check("drained", 34'(exp_q.size()), 34'h0);
  endtask

  // ------------------------------------------------------------
  // Clock, output monitor, watchdog
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Words leave in order, each computed from settings at its take
  always @(posedge pclk) begin
    if (presetn && pix_out_valid === 1'b1 && pix_out_ready === 1'b1) begin
      if (exp_q.size() == 0) check("extra_word", 34'h1, 34'h0);
      else check("pixel", {pix_out_luma, pix_out_u, pix_out_v, pix_out_phase}, exp_q.pop_front());
    end
  end
  // Whole run is a few hundred cycles
  initial begin
    #200000;
    err_total++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {pix_in_valid, pix_in_luma, pix_in_u, pix_in_v, pix_in_phase} = '0;
    pix_out_ready = 1'b1;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h02C, 32'h0000_0020, 1'b0);
    rd_chk(12'h030, 32'h0000_00D8, 1'b0);
    rd_chk(12'h034, 32'h0000_00FE, 1'b0);
    rd_chk(12'h038, 32'h0000_00B4, 1'b0);
    rd_chk(12'h03C, 32'h0000_0000, 1'b0);
    send(8'hFF, 8'h80, 8'h7F, 10'h155);
    send(8'h01, 8'hFF, 8'h81, 10'h3FF);
    drain();
    wr(12'h03C, 32'hFFFF_FF5A);
    rd_chk(12'h03C, 32'h0000_005A, 1'b0);
    apb(1'b1, 12'h03C, 32'h0000_0011, 4'h0, rdv, erv);
    rd_chk(12'h03C, 32'h0000_005A, 1'b0);
    apb(1'b1, 12'h040, 32'h0000_0011, 4'hF, rdv, erv);
    check("wr_err", {33'h0, erv}, 34'h1);
    rd_chk(12'h040, 32'h0000_0000, 1'b1);
    // Gain codes from zero to full scale, high bits set by read-modify-write
    foreach (codes[i]) begin
      apb(1'b0, 12'h02C, 32'h0, 4'hF, rdv, erv);
      wr(12'h02C, {rdv[31:3], {3{codes[i][8]}}});
      wr(12'h030, {23'h0, codes[i]});
      wr(12'h034, {23'h0, codes[i]});
      wr(12'h038, {23'h0, codes[i]});
      send(8'hC8, 8'h64, 8'h9C, 10'h000);
      drain();
      rd_chk(12'h02C, {24'h0, 5'h04, {3{codes[i][8]}}}, 1'b0);
    end
    // Hue offset under every decoding standard, then wrap of the phase
    wr(12'h03C, 32'h0000_0080);
    for (int s = 0; s < 4; s++) begin
      wr(12'h048, 32'(s));
      rd_chk(12'h048, 32'(s), 1'b0);
      send(8'h10, 8'h00, 8'h00, 10'h010);
    end
    wr(12'h048, 32'h0000_0000);
    wr(12'h03C, 32'h0000_0001);
    send(8'h10, 8'h00, 8'h00, 10'h3FF);
    drain();
    // Stall the receiver: fill, change a gain, then drain
    @(posedge pclk);
    pix_out_ready <= 1'b0;
    send(8'h20, 8'h30, 8'hD0, 10'h100);
    send(8'h21, 8'h31, 8'hD1, 10'h101);
    @(posedge pclk);
    check("in_ready_full", {33'h0, pix_in_ready}, 34'h0);
    rd_chk(12'h04C, 32'h0000_0016, 1'b0);
    wr(12'h034, 32'h0000_0040);
    @(posedge pclk);
    pix_out_ready <= 1'b1;
    send(8'h22, 8'h32, 8'hD2, 10'h102);
    drain();
    // Saturation doubled with the reset U:V ratio kept
    apb(1'b0, 12'h02C, 32'h0, 4'hF, rdv, erv);
    wr(12'h02C, {rdv[31:2], 2'h3});
    wr(12'h034, 32'h0000_00FC);
    wr(12'h038, 32'h0000_0068);
    send(8'h80, 8'h50, 8'hB0, 10'h000);
    drain();
    finish_test();
  end
endmodule

//--- vca_pkg.sv
// Package for the colour adjust stage: register map, reset values,
// field positions and fixed-point constants.
// Assumes 32-bit APB data with one register per aligned word.
package vca_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_MISC_CTRL = 12'h02C;
  localparam logic [11:0] OFS_LUMA_GAIN_LOW = 12'h030;
  localparam logic [11:0] OFS_U_GAIN_LOW = 12'h034;
  localparam logic [11:0] OFS_V_GAIN_LOW = 12'h038;
  localparam logic [11:0] OFS_HUE_PHASE_OFFSET = 12'h03C;
  localparam logic [11:0] OFS_VIDEO_STD = 12'h048;
  localparam logic [11:0] OFS_STATUS = 12'h04C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MISC_CTRL = 8'h20;
  localparam logic [7:0] RST_LUMA_GAIN_LOW = 8'hD8;
  localparam logic [7:0] RST_U_GAIN_LOW = 8'hFE;
  localparam logic [7:0] RST_V_GAIN_LOW = 8'hB4;
  localparam logic [7:0] RST_HUE_PHASE_OFFSET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions in the miscellaneous control register
  // ----------------------------------------------------------------
  localparam int MISC_LUMA_HIGH_POS = 2;
  localparam int MISC_U_HIGH_POS = 1;
  localparam int MISC_V_HIGH_POS = 0;

  // ----------------------------------------------------------------
  // Gain arithmetic: out = (s * code * recip + half) >> frac
  // recip = round(2^16 / unity code)
  // ----------------------------------------------------------------
  localparam int GAIN_FRAC_BITS = 16;
  localparam logic signed [31:0] GAIN_ROUND = 32'sh0000_8000;
  localparam logic [9:0] LUMA_RECIP = 10'h12F;
  localparam logic [9:0] U_RECIP = 10'h102;
  localparam logic [9:0] V_RECIP = 10'h16C;

  // Output sample ranges for clamping
  localparam logic signed [9:0] LUMA_MIN = 10'sh000;
  localparam logic signed [9:0] LUMA_MAX = 10'sh0FF;
  localparam logic signed [9:0] CHROMA_MIN = -10'sh080;
  localparam logic signed [9:0] CHROMA_MAX = 10'sh07F;

  // ----------------------------------------------------------------
  // Stream widths and buffer depth
  // ----------------------------------------------------------------
  localparam int PHASE_W = 10;
  localparam int PIX_W = 24 + PHASE_W;
  localparam int BUF_DEPTH = 2;

  // Decoding standard selected by software
  typedef enum logic [1:0] {
    VCA_STD_NTSC,
    VCA_STD_PAL,
    VCA_STD_SECAM,
    VCA_STD_DIGITAL
  } vca_std_t;

endpackage

//--- vca_stream_if.sv
// Valid/ready pixel stream between the stage's own modules.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface vca_stream_if #(
  parameter int WIDTH = vca_pkg::PIX_W
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );

  modport snk (
    input valid,
    input data,
    output ready
  );
endinterface
